// ### bench/crystal_model.sv
// crystal at the oscillator input pin of the start-up block
`timescale 1ns/1ps
module crystal_model #(
  parameter int HALF = 3
) (
  input  wire logic mclk,
  input  wire logic run,
  output logic      oscOut
);
  int cnt = 0;
  initial oscOut = 1'b0;
  // steady swing while running, still and low when stopped
  always @(posedge mclk) begin
    if (!run) begin
      cnt <= 0;
      oscOut <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      oscOut <= ~oscOut;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : crystal_model

// ### bench/oscillator_startup_and_tuning_test.sv
// self-checking bench for the oscillator start-up and tuning block
`timescale 1ns/1ps
module oscillator_startup_and_tuning_test;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        run = 1'b1;
  logic        crystalInPin, multFuseBit, powerupTimerDone;
  logic        wakeFromSleep, sleepMode, wrStrobe, rdStrobe;
  logic        execHold, clockStable, multEnable, multExt, bor, erase;
  logic [13:0] cfgWord;
  logic [3:0]  addr;
  logic [15:0] wrData, rdData, got;
  logic [4:0]  trimHi, trimMed;
  int          failCount, checkCount, n;

  always #10 mclk = ~mclk;
  crystal_model #(.HALF(3)) xtal_u (.mclk(mclk), .run(run),
    .oscOut(crystalInPin));
  oscillator_startup_and_tuning dut_u (.mclk(mclk), .reset(reset),
    .crystalInPin(crystalInPin), .cfgWord(cfgWord),
    .multFuseBit(multFuseBit), .powerupTimerDone(powerupTimerDone),
    .wakeFromSleep(wakeFromSleep), .sleepMode(sleepMode), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData_q(rdData), .execHold_q(execHold), .clockStable_q(clockStable),
    .multEnable_q(multEnable), .multFromExternal_q(multExt),
    .trimHighClock_q(trimHi), .trimMedClock_q(trimMed),
    .brownoutEnable_q(bor), .eraseProgram_q(erase));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic endSim;
    if (failCount == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : endSim
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge mclk);
    wrStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    #1 got = rdData;
  endtask : rd
  task automatic wrRd(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge mclk);
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    #1 got = rdData;
  endtask : wrRd
  task automatic pulse;
    @(posedge mclk);
    wakeFromSleep <= 1'b1;
    @(posedge mclk);
    wakeFromSleep <= 1'b0;
  endtask : pulse
  task automatic waitStable(input int lim);
    n = 0;
    while (clockStable !== 1'b1) begin
      if (n == lim) begin
        failCount++;
        endSim;
      end
      cyc(1);
      n++;
    end
  endtask : waitStable

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic startupScn;
    cyc(600);
    chk(16'(execHold), 16'h1);
    rd(osc_startup_pkg::ADDR_STATUS);
    chk(got, 16'h0);
    rd(osc_startup_pkg::ADDR_OSC_TRIM);
    chk(got, 16'h0);
    rd(4'hF);
    chk(got, 16'h0);
    @(posedge mclk);
    powerupTimerDone <= 1'b1;
    cyc(6000);
    chk(16'(execHold), 16'h1);
    chk(16'(clockStable), 16'h0);
    waitStable(400);
    chk(16'(execHold), 16'h0);
    rd(osc_startup_pkg::ADDR_STATUS);
    chk(got & 16'h3, 16'h1);
  endtask : startupScn
  task automatic wakeScn;
    @(posedge mclk);
    cfgWord[2:0] <= osc_startup_pkg::FOSC_LOW_POWER_XTAL;
    pulse();
    cyc(3000);
    chk(16'(clockStable), 16'h0);
    @(posedge mclk);
    cfgWord[2:0] <= osc_startup_pkg::FOSC_HIGH_SPEED_XTAL;
    pulse();
    cyc(6000);
    chk(16'(execHold), 16'h1);
    waitStable(400);
    chk(16'(execHold), 16'h0);
  endtask : wakeScn
  task automatic multScn;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      multFuseBit <= i[1];
      wr(osc_startup_pkg::ADDR_OSC_CTRL, 16'(i[0]));
      cyc(3);
      chk(16'(multEnable), 16'(i != 0));
    end
    chk(16'(multExt), 16'h1);
  endtask : multScn
  task automatic trimScn;
    wr(osc_startup_pkg::ADDR_OSC_TRIM, 16'h000F);
    cyc(10);
    chk(16'(trimHi == 5'h0F), 16'h0);
    cyc(790);
    chk(16'(trimHi), 16'h000F);
    chk(16'(trimMed), 16'h000F);
    rd(osc_startup_pkg::ADDR_STATUS);
    chk((got >> 4) & 16'h1F, 16'h000F);
    wrRd(osc_startup_pkg::ADDR_OSC_TRIM, 16'hFFF0);
    chk(got, 16'h0010);
    cyc(1600);
    chk(16'(trimHi), 16'h0010);
    chk(16'(trimMed), 16'h0010);
    chk(16'(clockStable), 16'h1);
  endtask : trimScn
  task automatic borScn;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      cfgWord[10:9] <= i[1:0];
      sleepMode <= i[2];
      wr(osc_startup_pkg::ADDR_PWR_CTRL, 16'(i[3]));
      cyc(3);
      chk(16'(bor), 16'(i[1:0] == 3 || (i[1:0] == 2 && !i[2]) ||
        (i[1:0] == 1 && i[3])));
    end
  endtask : borScn
  task automatic eraseScn;
    @(posedge mclk);
    cfgWord[7] <= 1'b1;
    n = 0;
    repeat (6) begin
      cyc(1);
      if (erase === 1'b1) n++;
    end
    chk(16'(n), 16'h1);
  endtask : eraseScn
  task automatic plainScn;
    @(posedge mclk);
    run <= 1'b0;
    cfgWord[2:0] <= 3'h4;
    pulse();
    #1 chk(16'(execHold), 16'h1);
    cyc(6);
    chk(16'(execHold), 16'h0);
    chk(16'(multExt), 16'h0);
  endtask : plainScn

  initial begin
    {multFuseBit, powerupTimerDone, wakeFromSleep, sleepMode} = 4'h0;
    {wrStrobe, rdStrobe, addr, wrData} = 22'h0;
    cfgWord = 14'h0001;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    startupScn();
    wakeScn();
    multScn();
    trimScn();
    borScn();
    eraseScn();
    plainScn();
    endSim();
  end
endmodule : oscillator_startup_and_tuning_test

// ### design/osc_startup_pkg.sv
// constants for the oscillator start-up and tuning block
package osc_startup_pkg;

  // ****************************************************************
  // bus and field widths
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CFG_W  = 14;
  localparam int TRIM_W = 5;
  localparam int FOSC_W = 3;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_OSC_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_OSC_TRIM = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PWR_CTRL = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CFG_WORD = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int OSC_CTRL_MULT_BIT = 0;
  localparam int PWR_CTRL_BOR_BIT  = 0;
  localparam int CFG_BOR_LSB       = 9;
  localparam int CFG_CP_BIT        = 7;
  localparam int CFG_PWRTE_BIT     = 5;
  localparam int CFG_FOSC_LSB      = 0;
  localparam int ST_STABLE_BIT     = 0;
  localparam int ST_BUSY_BIT       = 1;
  localparam int ST_MULT_BIT       = 2;
  localparam int ST_BOR_BIT        = 3;
  localparam int ST_TRIM_LSB       = 4;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [FOSC_W-1:0] FOSC_LOW_POWER_XTAL  = 3'h0;
  localparam logic [FOSC_W-1:0] FOSC_MEDIUM_XTAL     = 3'h1;
  localparam logic [FOSC_W-1:0] FOSC_HIGH_SPEED_XTAL = 3'h2;
  localparam logic [1:0] BOR_ALWAYS   = 2'h3;
  localparam logic [1:0] BOR_RUN_ONLY = 2'h2;
  localparam logic [1:0] BOR_SOFT     = 2'h1;
  localparam logic [1:0] BOR_OFF      = 2'h0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [TRIM_W-1:0] TRIM_RESET = 5'h00;
  localparam logic MULT_RUNTIME_RESET = 1'b0;
  localparam logic BOR_SOFT_RESET     = 1'b0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int STARTUP_OSC_COUNT = 1024;
  localparam int STARTUP_CNT_W     = 11;
  localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST =
    11'(STARTUP_OSC_COUNT - 1);
  localparam int CLK_PERIOD_NS = 20;
  localparam int TRIM_STEP_NS  = 1000;
  localparam int TRIM_STEP_CYC =
    (TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIM_DIV_W = 6;
  localparam logic [TRIM_DIV_W-1:0] TRIM_STEP_RELOAD =
    6'(TRIM_STEP_CYC - 1);

endpackage : osc_startup_pkg

// ### design/oscillator_startup_and_tuning.sv
// oscillator start-up gate, multiplier enable, trim and config decode
//
// Function
// - crystal modes count 1024 input oscillations
// - launch on power-on, after delay timer, wake
// - hold program counter while count runs
// - times-four multiplier takes external or internal
// - multiplier on when fuse bit is one
// - runtime bit enables multiplier unless fuse set
// - internal oscillator trimmed by software from calibration
// - trim drives both high and medium clocks
// - trim resets to zero, five-bit signed
// - 0Fh fastest, 10h slowest adjustment
// - frequency shifts gradually, no completion flag
// - slow internal oscillator never trimmed
// - brown-out field decode of four settings
// - field 01 uses software brown-out bit
// - turning code protection off erases program
`timescale 1ns/1ps
module oscillator_startup_and_tuning (
  input  wire logic                                 mclk,
  input  wire logic                                 reset,
  input  wire logic                                 crystalInPin,
  input  wire logic [osc_startup_pkg::CFG_W-1:0]    cfgWord,
  input  wire logic                                 multFuseBit,
  input  wire logic                                 powerupTimerDone,
  input  wire logic                                 wakeFromSleep,
  input  wire logic                                 sleepMode,
  input  wire logic [osc_startup_pkg::ADDR_W-1:0]   addr,
  input  wire logic [osc_startup_pkg::DATA_W-1:0]   wrData,
  input  wire logic                                 wrStrobe,
  input  wire logic                                 rdStrobe,
  output logic      [osc_startup_pkg::DATA_W-1:0]   rdData_q,
  output logic                                      execHold_q,
  output logic                                      clockStable_q,
  output logic                                      multEnable_q,
  output logic                                      multFromExternal_q,
  output logic      [osc_startup_pkg::TRIM_W-1:0]   trimHighClock_q,
  output logic      [osc_startup_pkg::TRIM_W-1:0]   trimMedClock_q,
  output logic                                      brownoutEnable_q,
  output logic                                      eraseProgram_q
);

  localparam int TW = osc_startup_pkg::TRIM_W;

  logic                                       xtalSync1_q;
  logic                                       xtalSync2_q;
  logic                                       xtalSync3_q;
  logic                                       porPend_q;
  logic                                       porPend_d;
  logic                                       multRuntime_q;
  logic                                       multRuntime_d;
  logic                                       borSoft_q;
  logic                                       borSoft_d;
  logic [TW-1:0]                              trimTarget_q;
  logic [TW-1:0]                              trimTarget_d;
  logic [TW-1:0]                              applied_q;
  logic [TW-1:0]                              applied_d;
  logic [osc_startup_pkg::TRIM_DIV_W-1:0]     stepCnt_q;
  logic [osc_startup_pkg::TRIM_DIV_W-1:0]     stepCnt_d;
  logic                                       cfgSeen_q;
  logic                                       cpPrev_q;
  logic [osc_startup_pkg::DATA_W-1:0]         rdData_d;
  logic                                       execHold_d;
  logic                                       clockStable_d;
  logic                                       multEnable_d;
  logic                                       multFromExternal_d;
  logic                                       brownoutEnable_d;
  logic                                       eraseProgram_d;
  logic [osc_startup_pkg::FOSC_W-1:0]         foscMode;
  logic [1:0]                                 borField;
  logic                                       xtalMode;
  logic                                       pwrtDisabled;
  logic                                       oscEdge;
  logic                                       launch;
  logic                                       cntBusy;
  logic                                       cntDone;
  logic                                       stepTick;
  logic                                       cpNow;

  // ****************************************************************
  // crystal pin synchroniser
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      xtalSync1_q <= 1'b0;
      xtalSync2_q <= 1'b0;
      xtalSync3_q <= 1'b0;
    end else begin
      xtalSync1_q <= crystalInPin;
      xtalSync2_q <= xtalSync1_q;
      xtalSync3_q <= xtalSync2_q;
    end
  end

  assign oscEdge = xtalSync2_q && !xtalSync3_q;

  // ****************************************************************
  // configuration decode
  // ****************************************************************
  assign foscMode = cfgWord[osc_startup_pkg::CFG_FOSC_LSB +:
                            osc_startup_pkg::FOSC_W];
  assign borField = cfgWord[osc_startup_pkg::CFG_BOR_LSB +: 2];
  assign pwrtDisabled = cfgWord[osc_startup_pkg::CFG_PWRTE_BIT];
  assign cpNow = cfgWord[osc_startup_pkg::CFG_CP_BIT];
  assign xtalMode = (foscMode == osc_startup_pkg::FOSC_LOW_POWER_XTAL) ||
                    (foscMode == osc_startup_pkg::FOSC_MEDIUM_XTAL) ||
                    (foscMode == osc_startup_pkg::FOSC_HIGH_SPEED_XTAL);

  // power-on launch waits for the delay timer if it is enabled
  assign launch = (porPend_q && (pwrtDisabled || powerupTimerDone)) ||
                  (!porPend_q && wakeFromSleep);

  startup_counter u_startup_counter (
    .mclk     (mclk),
    .reset    (reset),
    .launch   (launch),
    .xtalMode (xtalMode),
    .oscEdge  (oscEdge),
    .busy     (cntBusy),
    .done     (cntDone)
  );

  assign stepTick = (stepCnt_q == '0);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    porPend_d     = porPend_q && !launch;
    multRuntime_d = multRuntime_q;
    borSoft_d     = borSoft_q;
    trimTarget_d  = trimTarget_q;
    applied_d     = applied_q;
    stepCnt_d     = stepTick ? osc_startup_pkg::TRIM_STEP_RELOAD
                             : stepCnt_q - 6'h01;
    rdData_d      = '0;

    if (wrStrobe) begin
      case (addr)
        osc_startup_pkg::ADDR_OSC_CTRL: begin
          multRuntime_d = wrData[osc_startup_pkg::OSC_CTRL_MULT_BIT];
        end
        osc_startup_pkg::ADDR_OSC_TRIM: begin
          trimTarget_d = wrData[TW-1:0];
        end
        osc_startup_pkg::ADDR_PWR_CTRL: begin
          borSoft_d = wrData[osc_startup_pkg::PWR_CTRL_BOR_BIT];
        end
        default: begin
        end
      endcase
    end

    // walk one trim step per tick toward the target
    if (stepTick) begin
      if ($signed(applied_q) < $signed(trimTarget_q)) begin
        applied_d = applied_q + 5'h01;
      end else if ($signed(applied_q) > $signed(trimTarget_q)) begin
        applied_d = applied_q - 5'h01;
      end
    end

    if (rdStrobe) begin
      case (addr)
        osc_startup_pkg::ADDR_OSC_CTRL: begin
          rdData_d[osc_startup_pkg::OSC_CTRL_MULT_BIT] = multRuntime_q;
        end
        osc_startup_pkg::ADDR_OSC_TRIM: begin
          rdData_d[TW-1:0] = trimTarget_q;
        end
        osc_startup_pkg::ADDR_PWR_CTRL: begin
          rdData_d[osc_startup_pkg::PWR_CTRL_BOR_BIT] = borSoft_q;
        end
        osc_startup_pkg::ADDR_CFG_WORD: begin
          rdData_d[osc_startup_pkg::CFG_W-1:0] = cfgWord;
        end
        osc_startup_pkg::ADDR_STATUS: begin
          rdData_d[osc_startup_pkg::ST_STABLE_BIT] = clockStable_q;
          rdData_d[osc_startup_pkg::ST_BUSY_BIT]   = cntBusy;
          rdData_d[osc_startup_pkg::ST_MULT_BIT]   = multEnable_q;
          rdData_d[osc_startup_pkg::ST_BOR_BIT]    = brownoutEnable_q;
          rdData_d[osc_startup_pkg::ST_TRIM_LSB +: TW] = applied_q;
        end
        default: begin
          rdData_d = '0;
        end
      endcase
    end

    // execution stays frozen through power-up wait and the count
    execHold_d = porPend_d || launch || cntBusy;

    if (!xtalMode) begin
      clockStable_d = !porPend_q;
    end else if (launch) begin
      clockStable_d = 1'b0;
    end else if (cntDone) begin
      clockStable_d = 1'b1;
    end else begin
      clockStable_d = clockStable_q;
    end

    // fuse wins, runtime bit only matters while fuse is clear
    multEnable_d = multFuseBit ? 1'b1 : multRuntime_q;
    // external crystal feeds the multiplier, else internal source
    multFromExternal_d = xtalMode;

    case (borField)
      osc_startup_pkg::BOR_ALWAYS:   brownoutEnable_d = 1'b1;
      osc_startup_pkg::BOR_RUN_ONLY: brownoutEnable_d = !sleepMode;
      osc_startup_pkg::BOR_SOFT:     brownoutEnable_d = borSoft_q;
      osc_startup_pkg::BOR_OFF:      brownoutEnable_d = 1'b0;
      default:                       brownoutEnable_d = 1'b0;
    endcase

    // protection bit going from protected to open wipes program
    eraseProgram_d = cfgSeen_q && !cpPrev_q && cpNow;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      porPend_q          <= 1'b1;
      multRuntime_q      <= osc_startup_pkg::MULT_RUNTIME_RESET;
      borSoft_q          <= osc_startup_pkg::BOR_SOFT_RESET;
      trimTarget_q       <= osc_startup_pkg::TRIM_RESET;
      applied_q          <= osc_startup_pkg::TRIM_RESET;
      stepCnt_q          <= osc_startup_pkg::TRIM_STEP_RELOAD;
      cfgSeen_q          <= 1'b0;
      cpPrev_q           <= 1'b1;
      rdData_q           <= '0;
      execHold_q         <= 1'b1;
      clockStable_q      <= 1'b0;
      multEnable_q       <= 1'b0;
      multFromExternal_q <= 1'b0;
      trimHighClock_q    <= osc_startup_pkg::TRIM_RESET;
      trimMedClock_q     <= osc_startup_pkg::TRIM_RESET;
      brownoutEnable_q   <= 1'b0;
      eraseProgram_q     <= 1'b0;
    end else begin
      porPend_q          <= porPend_d;
      multRuntime_q      <= multRuntime_d;
      borSoft_q          <= borSoft_d;
      trimTarget_q       <= trimTarget_d;
      applied_q          <= applied_d;
      stepCnt_q          <= stepCnt_d;
      cfgSeen_q          <= 1'b1;
      cpPrev_q           <= cpNow;
      rdData_q           <= rdData_d;
      execHold_q         <= execHold_d;
      clockStable_q      <= clockStable_d;
      multEnable_q       <= multEnable_d;
      multFromExternal_q <= multFromExternal_d;
      // one trimmed base feeds both; slow oscillator has no trim port
      trimHighClock_q    <= applied_q;
      trimMedClock_q     <= applied_q;
      brownoutEnable_q   <= brownoutEnable_d;
      eraseProgram_q     <= eraseProgram_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_hold_busy;
    cntBusy |=> execHold_q;
  endproperty
  a_hold_busy: assert property (p_hold_busy)
    else $error("execution released while start-up count runs");

  property p_wake_launch;
    !porPend_q && wakeFromSleep && xtalMode |=> cntBusy;
  endproperty
  a_wake_launch: assert property (p_wake_launch)
    else $error("wake-up did not start the count");

  property p_por_wait;
    porPend_q && !pwrtDisabled && !powerupTimerDone |=> porPend_q;
  endproperty
  a_por_wait: assert property (p_por_wait)
    else $error("power-on count launched before delay timer");

  property p_fuse_mult;
    multFuseBit |=> multEnable_q;
  endproperty
  a_fuse_mult: assert property (p_fuse_mult)
    else $error("multiplier off while fuse bit set");

  property p_soft_mult;
    wrStrobe && addr == osc_startup_pkg::ADDR_OSC_CTRL ##1
      !multFuseBit |=> multEnable_q ==
      $past(wrData[osc_startup_pkg::OSC_CTRL_MULT_BIT], 2);
  endproperty
  a_soft_mult: assert property (p_soft_mult)
    else $error("runtime multiplier bit not followed");

  property p_trim_readback;
    wrStrobe && addr == osc_startup_pkg::ADDR_OSC_TRIM ##1
      rdStrobe && addr == osc_startup_pkg::ADDR_OSC_TRIM |=>
      rdData_q[TW-1:0] == $past(wrData[TW-1:0], 2);
  endproperty
  a_trim_readback: assert property (p_trim_readback)
    else $error("trim register readback mismatch");

  property p_trim_gradual;
    applied_q != $past(applied_q) |->
      (5'(applied_q - $past(applied_q)) == 5'h01) ||
      (5'(applied_q - $past(applied_q)) == 5'h1F);
  endproperty
  a_trim_gradual: assert property (p_trim_gradual)
    else $error("trim jumped by more than one step");

  property p_trim_both;
    ##1 trimHighClock_q == trimMedClock_q &&
      trimHighClock_q == $past(applied_q);
  endproperty
  a_trim_both: assert property (p_trim_both)
    else $error("high and medium trim differ");

  property p_bor_decode;
    borField == osc_startup_pkg::BOR_RUN_ONLY |=>
      brownoutEnable_q == !$past(sleepMode);
  endproperty
  a_bor_decode: assert property (p_bor_decode)
    else $error("brown-out run-only decode wrong");

  property p_bor_soft;
    borField == osc_startup_pkg::BOR_SOFT |=>
      brownoutEnable_q == $past(borSoft_q);
  endproperty
  a_bor_soft: assert property (p_bor_soft)
    else $error("brown-out software bit not used");

  property p_erase;
    cfgSeen_q && !cpPrev_q && cpNow |=> eraseProgram_q ##1
      !eraseProgram_q || $past(cfgSeen_q && !cpPrev_q && cpNow);
  endproperty
  a_erase: assert property (p_erase)
    else $error("protection release did not erase once");

  c_xtal_stable: cover property ($rose(clockStable_q) && xtalMode);
  c_trim_max: cover property (trimHighClock_q == 5'h0F);
  c_trim_min: cover property (trimHighClock_q == 5'h10);
  c_erase: cover property (eraseProgram_q);

endmodule : oscillator_startup_and_tuning

// ### design/startup_counter.sv
// crystal oscillation counter that gates execution after start-up
`timescale 1ns/1ps
module startup_counter (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic launch,
  input  wire logic xtalMode,
  input  wire logic oscEdge,
  output logic      busy,
  output logic      done
);

  typedef enum logic {CNT_IDLE, CNT_RUN} cnt_state_t;

  cnt_state_t                                 state_q;
  cnt_state_t                                 state_d;
  logic [osc_startup_pkg::STARTUP_CNT_W-1:0]  cnt_q;
  logic [osc_startup_pkg::STARTUP_CNT_W-1:0]  cnt_d;
  logic                                       done_q;
  logic                                       done_d;

  // ****************************************************************
  // count
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    if (launch) begin
      // any launch clears the count; only a launch in a crystal mode restarts it
      cnt_d   = '0;
      state_d = xtalMode ? CNT_RUN : CNT_IDLE;
    end else begin
      case (state_q)
        CNT_RUN: begin
          if (!xtalMode) begin
            state_d = CNT_IDLE;
          end else if (oscEdge) begin
            if (cnt_q == osc_startup_pkg::STARTUP_LAST) begin
              state_d = CNT_IDLE;
              done_d  = 1'b1;
            end else begin
              cnt_d = cnt_q + 11'h001;
            end
          end
        end
        CNT_IDLE: begin
          state_d = CNT_IDLE;
        end
        default: begin
          state_d = CNT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= CNT_IDLE;
      cnt_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
    end
  end

  assign busy = (state_q == CNT_RUN);
  assign done = done_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [11:0] edgeSeen_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      edgeSeen_q <= '0;
    end else if (launch) begin
      edgeSeen_q <= '0;
    end else if (busy && oscEdge && xtalMode) begin
      edgeSeen_q <= edgeSeen_q + 12'h001;
    end
  end

  property p_count_full;
    @(posedge mclk) disable iff (reset)
      $rose(done_q) |-> edgeSeen_q == 12'h400;
  endproperty
  a_count_full: assert property (p_count_full)
    else $error("start-up done before 1024 oscillations");

  property p_restart;
    @(posedge mclk) disable iff (reset)
      launch && xtalMode |=> busy && cnt_q == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("launch did not restart the count");

  property p_no_xtal;
    @(posedge mclk) disable iff (reset)
      !xtalMode |=> !busy && !done_q;
  endproperty
  a_no_xtal: assert property (p_no_xtal)
    else $error("counter ran outside a crystal mode");

  c_count_done: cover property (@(posedge mclk) disable iff (reset)
    $rose(done_q));

endmodule : startup_counter
